// File: pkg/mcr_cfg.svh
// Offsets, field positions, reset values and timing counts of the module control block.
// Assumes a 4 KiB register window addressed in bytes, one aligned 32-bit word per register.
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

`define MCR_ADDR_W        12
`define MCR_CTRL_OFS      12'h000
`define MCR_STAT_OFS      12'h004
`define MCR_N_UNITS       4
`define MCR_N_SRC         8
`define MCR_DIS_LSB       4
`define MCR_GATE_BIT      0
`define MCR_CTRL_WMASK    32'h000000F1
`define MCR_CTRL_RST      32'h00000000
`define MCR_CAL_LSB       4
`define MCR_MSI_BIT       3
`define MCR_INTA_BIT      2
`define MCR_ERR_BIT       0
`define MCR_RST_HOLD_CYC  2

`endif

// File: pkg/mcr_pkg.sv
// Types shared by the module control block.
// Assumes mcr_cfg.svh is on the include path.
`include "mcr_cfg.svh"
`default_nettype none

package mcr_pkg;

    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [`MCR_ADDR_W-1:0] addr;
        logic [31:0]            wdata;
    } mcr_bus_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } mcr_bus_rsp_t;

endpackage

`default_nettype wire

// File: verilog/mcr_unit_ctl.sv
// Run and reset control for one deserializer unit, driven by its disable bit.
// Assumes dis_in comes from a register in the same clock domain.
`include "mcr_cfg.svh"
`default_nettype none

module mcr_unit_ctl #(
    parameter int RST_HOLD = `MCR_RST_HOLD_CYC
) (
    input  wire logic mclk_in,
    input  wire logic rst_in,
    input  wire logic dis_in,
    input  wire logic cal_in,
    output var  logic run_out,
    output var  logic rst_out,
    output var  logic cal_out
);

    localparam int CW = $clog2(RST_HOLD + 1);

    if (RST_HOLD < 1 || RST_HOLD > 7) begin : g_chk
        $error("RST_HOLD must lie between 1 and 7");
    end

    logic          dis_prev_ff;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          nxt_rst;
    wire           fall_w = dis_prev_ff & ~dis_in;

    assign nxt_cnt = fall_w ? CW'(RST_HOLD) :
                     (cnt_ff != '0) ? cnt_ff - CW'(1) : '0;
    assign nxt_rst = dis_in | (nxt_cnt != '0);

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            dis_prev_ff <= 1'b0;
            cnt_ff      <= '0;
            run_out     <= 1'b0;
            rst_out     <= 1'b1;
            cal_out     <= 1'b0;
        end else begin
            dis_prev_ff <= dis_in;
            cnt_ff      <= nxt_cnt;
            run_out     <= ~nxt_rst;
            rst_out     <= nxt_rst;
            // A unit in reset has lost its calibration, so it never reports done.
            cal_out     <= cal_in & ~nxt_rst;
        end
    end

    property p_run_follows;
        @(posedge mclk_in) disable iff (rst_in)
        dis_in |=> !run_out && rst_out;
    endproperty
    a_run_follows: assert property (p_run_follows) else $error("disabled unit still runs");

    sequence s_toggle;
        dis_in ##1 !dis_in;
    endsequence

    property p_toggle_resets;
        @(posedge mclk_in) disable iff (rst_in)
        s_toggle |=> rst_out && !run_out && !cal_out;
    endproperty
    a_toggle_resets: assert property (p_toggle_resets) else $error("toggle gave no reset");

    property p_reset_ends;
        @(posedge mclk_in) disable iff (rst_in)
        s_toggle ##0 (!dis_in)[*8] |=> run_out && !rst_out;
    endproperty
    a_reset_ends: assert property (p_reset_ends) else $error("unit reset never released");

endmodule

`default_nettype wire

// File: verilog/mcr_top.sv
// Module control register: per-unit disable and reset, master interrupt gate, status readback.
// Assumes a single-cycle register port from the host bridge, all inputs synchronous to mclk_in.
`include "mcr_cfg.svh"
`default_nettype none

module mcr_top
    import mcr_pkg::*;
#(
    parameter int N_UNITS  = `MCR_N_UNITS,
    parameter int N_SRC    = `MCR_N_SRC,
    parameter int RST_HOLD = `MCR_RST_HOLD_CYC
) (
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    input  wire mcr_bus_req_t       bus_req_in,
    output var  mcr_bus_rsp_t       bus_rsp_out,
    input  wire logic [N_UNITS-1:0] cal_done_in,
    input  wire logic [N_SRC-1:0]   irq_src_in,
    input  wire logic               mode_msi_in,
    input  wire logic               mode_inta_in,
    output var  logic [N_UNITS-1:0] unit_run_out,
    output var  logic [N_UNITS-1:0] unit_rst_out,
    output var  logic               cfg_err_out,
    output var  logic               irq_out
);

    // The disable field and the status word are laid out for exactly four units.
    if (N_UNITS != 4 || N_SRC < 1) begin : g_chk
        $error("N_UNITS must be 4 and N_SRC at least 1");
    end

    logic [31:0]        ctrl_ff;
    logic               mode_msi_ff;
    logic               mode_inta_ff;
    logic [N_UNITS-1:0] cal_w;

    wire         wr_ctrl_w  = bus_req_in.wr && (bus_req_in.addr == `MCR_CTRL_OFS);
    wire         rd_ctrl_w  = bus_req_in.addr == `MCR_CTRL_OFS;
    wire         rd_stat_w  = bus_req_in.addr == `MCR_STAT_OFS;
    wire  [31:0] nxt_ctrl   = bus_req_in.wdata & `MCR_CTRL_WMASK;
    wire         gate_w     = ctrl_ff[`MCR_GATE_BIT];
    wire         nxt_err    = mode_msi_in & mode_inta_in;
    wire         nxt_irq    = (|irq_src_in) & gate_w & ~nxt_err;
    wire  [31:0] stat_w     = {24'h000000, cal_w, mode_msi_ff, mode_inta_ff, 1'b0, cfg_err_out};
    wire  [31:0] nxt_rdata  = rd_ctrl_w ? (ctrl_ff & `MCR_CTRL_WMASK) :
                              rd_stat_w ? stat_w : 32'h00000000;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ctrl_ff <= `MCR_CTRL_RST;
        end else if (wr_ctrl_w) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            mode_msi_ff  <= 1'b0;
            mode_inta_ff <= 1'b0;
            cfg_err_out  <= 1'b0;
            irq_out      <= 1'b0;
            bus_rsp_out  <= '0;
        end else begin
            mode_msi_ff       <= mode_msi_in;
            mode_inta_ff      <= mode_inta_in;
            cfg_err_out       <= nxt_err;
            irq_out           <= nxt_irq;
            bus_rsp_out.valid <= bus_req_in.rd;
            bus_rsp_out.data  <= bus_req_in.rd ? nxt_rdata : 32'h00000000;
        end
    end

    for (genvar i = 0; i < N_UNITS; i++) begin : g_unit
        mcr_unit_ctl #(
            .RST_HOLD (RST_HOLD)
        ) u_unit (
            .mclk_in (mclk_in),
            .rst_in  (rst_in),
            .dis_in  (ctrl_ff[`MCR_DIS_LSB + i]),
            .cal_in  (cal_done_in[i]),
            .run_out (unit_run_out[i]),
            .rst_out (unit_rst_out[i]),
            .cal_out (cal_w[i])
        );
    end

    property p_wr_ctrl;
        @(posedge mclk_in) disable iff (rst_in)
        wr_ctrl_w |=> (ctrl_ff == $past(nxt_ctrl))
                      ##1 ((unit_run_out & $past(ctrl_ff[7:4])) == 4'h0
                           && (unit_rst_out & $past(ctrl_ff[7:4])) == $past(ctrl_ff[7:4]));
    endproperty
    a_wr_ctrl: assert property (p_wr_ctrl) else $error("unit enables miss the disable field");

    property p_irq_fires;
        @(posedge mclk_in) disable iff (rst_in)
        ((|irq_src_in) && ctrl_ff[`MCR_GATE_BIT]
         && !(mode_msi_in && mode_inta_in)) |=> irq_out;
    endproperty
    a_irq_fires: assert property (p_irq_fires) else $error("gated source gave no interrupt");

    property p_gate_blocks;
        @(posedge mclk_in) disable iff (rst_in)
        !gate_w |=> !irq_out;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("interrupt passed a closed gate");

    property p_gate_pol;
        @(posedge mclk_in) disable iff (rst_in)
        irq_out |-> $past(ctrl_ff[0]) && $past(|irq_src_in);
    endproperty
    a_gate_pol: assert property (p_gate_pol) else $error("interrupt without gate bit set");

    sequence s_stat_read;
        bus_req_in.rd && rd_stat_w ##1 bus_rsp_out.valid;
    endsequence

    property p_cal_read;
        @(posedge mclk_in) disable iff (rst_in)
        s_stat_read |-> bus_rsp_out.data[7:4] == $past(cal_w)
                        && bus_rsp_out.data[0] == $past(cfg_err_out);
    endproperty
    a_cal_read: assert property (p_cal_read) else $error("status read shows wrong state");

    property p_err_blocks;
        @(posedge mclk_in) disable iff (rst_in)
        (mode_msi_in && mode_inta_in) |=> cfg_err_out && !irq_out;
    endproperty
    a_err_blocks: assert property (p_err_blocks) else $error("config error did not block");

    sequence s_ctrl_read;
        bus_req_in.rd && rd_ctrl_w ##1 bus_rsp_out.valid;
    endsequence

    property p_rsv_zero;
        @(posedge mclk_in) disable iff (rst_in)
        s_ctrl_read |-> (bus_rsp_out.data & ~`MCR_CTRL_WMASK) == 32'h00000000
                        && (ctrl_ff & ~`MCR_CTRL_WMASK) == 32'h00000000;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved control bits not zero");

endmodule

`default_nettype wire

// File: testbench/mcr_unit_model.sv
// Model of the four deserializer units behind the control block.
// Assumes run_in is registered by the block under test on the same clock.
`default_nettype none

module mcr_unit_model #(
    parameter int CAL_DLY = 4
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic [3:0] run_in,
    output var  logic [3:0] cal_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt [4];
    // A stopped unit loses calibration, so a toggled unit must train again.
    always_ff @(posedge mclk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (rst_in || !run_in[i]) begin
                cnt[i] <= 0;
                cal_done_out[i] <= 1'b0;
            end else begin
                cnt[i] <= (cnt[i] < CAL_DLY) ? cnt[i] + 1 : cnt[i];
                cal_done_out[i] <= (cnt[i] >= CAL_DLY);
            end
        end
    end
endmodule

`default_nettype wire

// File: testbench/test_mcr_top.sv
// Bench for the module control block: register port, unit control, interrupt gate.
// Assumes mcr_pkg is compiled first and mcr_cfg.svh is on the include path.
`include "mcr_cfg.svh"
`default_nettype none

module test_mcr_top
    import mcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 3;
    logic         mclk_in = 1'b0;
    logic         rst_in = 1'b1;
    mcr_bus_req_t req = '0;
    mcr_bus_rsp_t rsp;
    logic [3:0]   cal, run, urst;
    logic [7:0]   src = 8'h00;
    logic         msi = 1'b1;
    logic         inta = 1'b0;
    logic         err, irq;
    logic [31:0]  rdat;
    int           failures = 0;
    int           cmp_count = 0;

    initial forever #20 mclk_in = ~mclk_in;

    mcr_top #(.RST_HOLD(HOLD)) uut (.mclk_in(mclk_in), .rst_in(rst_in), .bus_req_in(req),
        .bus_rsp_out(rsp), .cal_done_in(cal), .irq_src_in(src), .mode_msi_in(msi),
        .mode_inta_in(inta), .unit_run_out(run), .unit_rst_out(urst), .cfg_err_out(err),
        .irq_out(irq));
    mcr_unit_model units (.mclk_in(mclk_in), .rst_in(rst_in), .run_in(run), .cal_done_out(cal));

    task automatic test_done();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_pin(input string what, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk_in);
        req <= '0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge mclk_in);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk_in);
        req <= '0;
        #1;
        chk_pin("read valid", 4'h1, {3'h0, rsp.valid});
        rdat = rsp.data;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    // Polls the status word until every unit reports calibration; a stuck unit ends the run.
    task automatic wait_cal();
        rd(`MCR_STAT_OFS);
        for (int n = 0; n < 20 && rdat[7:4] !== 4'hF; n++) rd(`MCR_STAT_OFS);
        if (rdat[7:4] !== 4'hF) begin
            failures++;
            $display("mismatch calibration wait expected %h seen %h", 4'hF, rdat[7:4]);
            test_done();
        end
    endtask

    initial begin
        step(9);
        chk_pin("unit reset", 4'hF, urst);
        @(posedge mclk_in);
        rst_in <= 1'b0;
        step(2);
        chk_pin("unit run", 4'hF, run);
        rd(`MCR_CTRL_OFS);
        chk_word("control", 32'h0, rdat);
        wr(`MCR_CTRL_OFS, 32'hFFFFFFFF);
        rd(`MCR_CTRL_OFS);
        chk_word("control", 32'hF1, rdat);
        chk_pin("unit run", 4'h0, run);
        wr(`MCR_CTRL_OFS, 32'h0);
        step(HOLD + 1);
        chk_pin("unit run", 4'hF, run);
        wait_cal();
        chk_word("status", 32'hF8, rdat);
        for (int i = 0; i < 4; i++) begin
            wr(`MCR_CTRL_OFS, 32'h10 << i);
            step(1);
            chk_pin("unit run", 4'hF & ~(4'h1 << i), run);
            step(2);
            rd(`MCR_STAT_OFS);
            chk_word("status", {24'h0, 4'hF & ~(4'h1 << i), 4'h8}, rdat);
            wr(`MCR_CTRL_OFS, 32'h0);
            step(HOLD);
            chk_pin("unit reset", 4'h1 << i, urst);
            step(1);
            chk_pin("unit run", 4'hF, run);
        end
        @(posedge mclk_in);
        src <= 8'hFF;
        step(2);
        chk_pin("irq", 4'h0, {3'h0, irq});
        wr(`MCR_CTRL_OFS, 32'h1);
        for (int j = 0; j < 8; j++) begin
            @(posedge mclk_in);
            src <= 8'h1 << j;
            step(1);
            chk_pin("irq", 4'h1, {3'h0, irq});
        end
        @(posedge mclk_in);
        src <= 8'h00;
        step(1);
        chk_pin("irq", 4'h0, {3'h0, irq});
        @(posedge mclk_in);
        src <= 8'h80;
        inta <= 1'b1;
        step(2);
        chk_pin("config error", 4'h1, {3'h0, err});
        chk_pin("irq", 4'h0, {3'h0, irq});
        wait_cal();
        rd(`MCR_STAT_OFS);
        chk_word("status", 32'hFD, rdat);
        wr(`MCR_STAT_OFS, 32'hFFFFFFFF);
        rd(`MCR_CTRL_OFS);
        chk_word("control", 32'h1, rdat);
        rd(12'h1FC);
        chk_word("unmapped", 32'h0, rdat);
        test_done();
    end
endmodule

`default_nettype wire
